// ---- design/ats_acq_timer.sv ----
// acquisition stage timer: length is response time times a fixed ratio
// assumes start and stop come from the sequencer on the same clock
`timescale 1ns/1ps
module ats_acq_timer
  import ats_pkg::*;
#(
  parameter int unsigned UNIT_CYC = ACQ_UNIT_CYC
)(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // control
  input  wire logic              start_i,
  input  wire logic              stop_i,
  input  wire logic [RESP_W-1:0] resp_time_i,
  // status
  output logic                   active_o,
  output logic                   done_o
);

  logic [31:0]               pre;
  logic [RESP_W+RATIO_W-1:0] units;
  logic [RESP_W+RATIO_W-1:0] target;
  logic                      unit_tick;

  assign unit_tick = (pre == 32'(UNIT_CYC - 1));

  // prescaler and unit counter, start wins over stop
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (reset_i)
    begin
      active_o <= 1'b0;
      pre      <= '0;
      units    <= '0;
      target   <= '0;
    end
    else if (start_i)
    begin
      active_o <= 1'b1;
      pre      <= '0;
      units    <= '0;
      // stage length tracks the process response time
      target   <= (resp_time_i == '0) ? (RESP_W+RATIO_W)'(1) : resp_time_i * ACQ_RATIO;
    end
    else if (stop_i)
      active_o <= 1'b0;
    else if (active_o)
    begin
      pre <= unit_tick ? '0 : pre + 32'd1;
      if (unit_tick)
      begin
        units <= units + (RESP_W+RATIO_W)'(1);
        if (units + (RESP_W+RATIO_W)'(1) == target)
        begin
          active_o <= 1'b0;
          done_o   <= 1'b1;
        end
      end
    end
  end

endmodule

// ---- design/ats_pkg.sv ----
// autotune mode sequencer: register map, field layout, modes, states, timing
// assumes a 200 MHz system clock and a 32-bit axi4-lite register bus
package ats_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_GAIN_PI = 8'h08;
  localparam logic [7:0] OFF_GAIN_D = 8'h0C;
  localparam logic [7:0] OFF_RESP   = 8'h10;
  localparam int         ADDR_W     = 8;

  // control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_MSB = 2;
  localparam int CTRL_RUN     = 3;
  localparam int CTRL_CRST    = 4;

  // status register fields
  localparam int STAT_ST_LSB  = 0;
  localparam int STAT_ST_MSB  = 1;
  localparam int STAT_IND     = 2;
  localparam int STAT_ONOFF   = 3;
  localparam int STAT_REFV    = 4;
  localparam int STAT_MON     = 5;
  localparam int STAT_SEL_LSB = 8;
  localparam int STAT_SEL_MSB = 10;

  // tuning selection codes
  localparam logic [2:0] SEL_OFF   = 3'h0;
  localparam logic [2:0] SEL_FAST  = 3'h1;
  localparam logic [2:0] SEL_FULL  = 3'h2;
  localparam logic [2:0] SEL_SELF  = 3'h3;
  localparam logic [2:0] SEL_ADAPT = 3'h4;
  localparam logic [2:0] SEL_EACH  = 3'h5;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // widths
  localparam int GAIN_W  = 16;
  localparam int RESP_W  = 16;
  localparam int RATIO_W = 4;

  // timing: slow flash half period and acquisition time base
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned FLASH_HALF_MS  = 500;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned ACQ_UNIT_US    = 1000;
  localparam int unsigned ACQ_UNIT_CYC   = ACQ_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam logic [RATIO_W-1:0] ACQ_RATIO = 4'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_TUNE, ST_ACQ, ST_MON} ats_state_t;
  typedef enum logic [1:0] {KIND_USER, KIND_SELF, KIND_ADAPT} ats_kind_t;

  typedef struct packed {
    logic [GAIN_W-1:0] d;
    logic [GAIN_W-1:0] i;
    logic [GAIN_W-1:0] p;
  } ats_gains_t;

endpackage

// ---- design/ats_sequencer.sv ----
// autotune mode sequencer: operator selection, tuning runs, self-adaptive loop
// assumes tuning engine and behaviour monitor on CLK_SYS_I, axi4-lite master
//
// Function
// - selection off: never start tuning, by request or by itself
// - quick selection starts a short tuning run at once
// - full selection starts a precise tuning run at once
// - operator run done: load gains, selection back to off
// - indicator steady on during quick or full run, off after
// - on/off control while tuning, pid with new gains afterwards
// - self-adaptive selection starts a full run when control enabled
// - skip that initial run while stored reference is valid
// - operator quick or full run clears stored reference
// - after self-adaptive run, acquire reference with slow flashing indicator
// - acquisition end: indicator off, pid with monitoring active
// - monitoring: significant deviation starts new tuning run
// - every self re-tuning is followed by fresh acquisition
// - acquisition length proportional to process response time
// - retune-then-adapt: full run, then self-adaptive selection written
// - tune-on-each-reset: self-adaptive, plus full run on control reset
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module ats_sequencer
  import ats_pkg::*;
#(
  parameter int unsigned FLASH_CYC = FLASH_HALF_CYC,
  parameter int unsigned UNIT_CYC  = ACQ_UNIT_CYC
)(
  // clock and reset
  input  wire logic              CLK_SYS_I,
  input  wire logic              RESET_I,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  // tuning engine
  output logic                   TUNE_START_O,
  output logic                   TUNE_FAST_O,
  input  wire logic              TUNE_DONE_I,
  input  wire ats_gains_t        TUNE_GAINS_I,
  input  wire logic [RESP_W-1:0] RESP_TIME_I,
  // behaviour monitor
  output logic                   ACQ_ACTIVE_O,
  output logic                   MON_ACTIVE_O,
  input  wire logic              DEVIATION_I,
  // control action
  output logic                   TUNING_IND_O,
  output logic                   ONOFF_MODE_O,
  output ats_gains_t             GAINS_O
);

  ats_state_t        state;
  ats_state_t        next_state;
  ats_kind_t         kind;
  ats_kind_t         next_kind;
  logic [2:0]        sel;
  logic              run;
  logic              ref_valid;
  logic [RESP_W-1:0] resp_q;
  logic [31:0]       flash_cnt;
  logic              flash_ph;
  logic              next_ph;

  // write channel holding
  logic              aw_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              aw_fire;
  logic              w_fire;
  logic              wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic [31:0]       rd_mux;
  logic              rd_hit;

  // sequencer events
  logic              ctrl_wr;
  logic [2:0]        new_sel;
  logic              user_req;
  logic              ctl_rst;
  logic              self_sel;
  logic              tune_done;
  logic              acq_start;
  logic              acq_done;
  logic              acq_active;

  // bus handshakes
  assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O  = !w_held && !S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign aw_fire = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  assign w_fire  = S_AXI_WVALID_I && S_AXI_WREADY_O;
  assign wr_go   = (aw_held || aw_fire) && (w_held || w_fire) && !S_AXI_BVALID_O;
  assign wr_addr = aw_held ? aw_addr_q : S_AXI_AWADDR_I;
  assign wr_data = w_held ? w_data_q : S_AXI_WDATA_I;
  assign wr_strb = w_held ? w_strb_q : S_AXI_WSTRB_I;

  // address and data halves may arrive in either order
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end
    else
    begin
      if (aw_fire)
        aw_addr_q <= S_AXI_AWADDR_I;
      if (w_fire)
      begin
        w_data_q <= S_AXI_WDATA_I;
        w_strb_q <= S_AXI_WSTRB_I;
      end
      aw_held <= wr_go ? 1'b0 : (aw_held || aw_fire);
      w_held  <= wr_go ? 1'b0 : (w_held || w_fire);
    end
  end

  // write response, unmapped or read-only offsets answer slverr
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= (wr_addr == OFF_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_BREADY_I)
      S_AXI_BVALID_O <= 1'b0;
  end

  // read data mux
  always_comb
  begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (S_AXI_ARADDR_I)
      OFF_CTRL:
      begin
        rd_mux[CTRL_SEL_MSB:CTRL_SEL_LSB] = sel;
        rd_mux[CTRL_RUN]                  = run;
      end
      OFF_STATUS:
      begin
        rd_mux[STAT_ST_MSB:STAT_ST_LSB]   = state;
        rd_mux[STAT_IND]                  = TUNING_IND_O;
        rd_mux[STAT_ONOFF]                = ONOFF_MODE_O;
        rd_mux[STAT_REFV]                 = ref_valid;
        rd_mux[STAT_MON]                  = MON_ACTIVE_O;
        rd_mux[STAT_SEL_MSB:STAT_SEL_LSB] = sel;
      end
      OFF_GAIN_PI: rd_mux = {GAINS_O.i, GAINS_O.p};
      OFF_GAIN_D:  rd_mux[GAIN_W-1:0] = GAINS_O.d;
      OFF_RESP:    rd_mux[RESP_W-1:0] = resp_q;
      default:     rd_hit = 1'b0;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= '0;
      S_AXI_RRESP_O  <= RESP_OKAY;
    end
    else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
    begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= rd_mux;
      S_AXI_RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (S_AXI_RREADY_I)
      S_AXI_RVALID_O <= 1'b0;
  end

  // control register decode
  assign ctrl_wr   = wr_go && (wr_addr == OFF_CTRL) && wr_strb[0];
  assign new_sel   = wr_data[CTRL_SEL_MSB:CTRL_SEL_LSB];
  assign ctl_rst   = ctrl_wr && wr_data[CTRL_CRST];
  assign user_req  = ctrl_wr && (state != ST_TUNE) &&
                     (new_sel == SEL_FAST || new_sel == SEL_FULL ||
                      new_sel == SEL_ADAPT);
  assign self_sel  = (sel == SEL_SELF) || (sel == SEL_EACH);
  assign tune_done = (state == ST_TUNE) && TUNE_DONE_I;
  assign acq_start = tune_done && (kind != KIND_USER);

  // next state of the sequencer
  always_comb
  begin
    next_state = state;
    next_kind  = kind;
    case (state)
      ST_IDLE:
        if (user_req)
        begin
          next_state = ST_TUNE;
          next_kind  = (new_sel == SEL_ADAPT) ? KIND_ADAPT : KIND_USER;
        end
        else if (self_sel && run) // off never reaches here
        begin
          next_kind = KIND_SELF;
          if (sel == SEL_EACH && ctl_rst)
            next_state = ST_TUNE;
          else if (ref_valid)
            next_state = ST_MON;
          else
            next_state = ST_TUNE;
        end
      ST_TUNE:
        if (tune_done)
          next_state = (kind == KIND_USER) ? ST_IDLE : ST_ACQ;
      ST_ACQ, ST_MON:
        if (user_req)
        begin
          next_state = ST_TUNE;
          next_kind  = (new_sel == SEL_ADAPT) ? KIND_ADAPT : KIND_USER;
        end
        else if (!self_sel || !run)
          next_state = ST_IDLE;
        else if (sel == SEL_EACH && ctl_rst)
        begin
          next_state = ST_TUNE;
          next_kind  = KIND_SELF;
        end
        else if (state == ST_ACQ && acq_done)
          next_state = ST_MON;
        else if (state == ST_MON && DEVIATION_I)
        begin
          next_state = ST_TUNE;
          next_kind  = KIND_SELF;
        end
      default:
        next_state = ST_IDLE;
    endcase
  end

  // state and run kind
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      state <= ST_IDLE;
      kind  <= KIND_USER;
    end
    else
    begin
      state <= next_state;
      kind  <= next_kind;
    end
  end

  // selection and enable, software write wins over hardware rewrite
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      sel <= SEL_OFF;
      run <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      sel <= new_sel;
      run <= wr_data[CTRL_RUN];
    end
    else if (tune_done && kind == KIND_USER)
      sel <= SEL_OFF;
    else if (tune_done && kind == KIND_ADAPT)
      sel <= SEL_SELF;
  end

  // stored reference validity
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
      ref_valid <= 1'b0;
    else if (user_req && new_sel != SEL_ADAPT)
      ref_valid <= 1'b0;
    else if (acq_start)
      ref_valid <= 1'b0;
    else if (state == ST_ACQ && acq_done && next_state == ST_MON)
      ref_valid <= 1'b1;
  end

  // gains and response time loaded on the done pulse
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      GAINS_O <= '0;
      resp_q  <= '0;
    end
    else if (tune_done)
    begin
      GAINS_O <= TUNE_GAINS_I;
      resp_q  <= RESP_TIME_I;
    end
  end

  // engine start pulse and run length
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      TUNE_START_O <= 1'b0;
      TUNE_FAST_O  <= 1'b0;
    end
    else
    begin
      TUNE_START_O <= (next_state == ST_TUNE) && (state != ST_TUNE);
      if ((next_state == ST_TUNE) && (state != ST_TUNE))
        TUNE_FAST_O <= user_req && (new_sel == SEL_FAST);
    end
  end

  // slow flash phase, starts lit on entry to acquisition
  assign next_ph = (next_state != ST_ACQ) ? 1'b1 :
                   (state == ST_ACQ && flash_cnt == 32'(FLASH_CYC - 1)) ? !flash_ph :
                   flash_ph;

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      flash_cnt <= '0;
      flash_ph  <= 1'b1;
    end
    else
    begin
      flash_ph <= next_ph;
      if (next_state != ST_ACQ || state != ST_ACQ || flash_cnt == 32'(FLASH_CYC - 1))
        flash_cnt <= '0;
      else
        flash_cnt <= flash_cnt + 32'd1;
    end
  end

  // indicator and control action follow the next state
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      TUNING_IND_O <= 1'b0;
      ONOFF_MODE_O <= 1'b0;
      ACQ_ACTIVE_O <= 1'b0;
      MON_ACTIVE_O <= 1'b0;
    end
    else
    begin
      TUNING_IND_O <= (next_state == ST_TUNE) ||
                      (next_state == ST_ACQ && next_ph);
      ONOFF_MODE_O <= (next_state == ST_TUNE);
      ACQ_ACTIVE_O <= (next_state == ST_ACQ);
      MON_ACTIVE_O <= (next_state == ST_MON);
    end
  end

  // acquisition stage timer
  ats_acq_timer #(
    .UNIT_CYC    (UNIT_CYC)
  ) u_acq (
    .clk_i       (CLK_SYS_I),
    .reset_i     (RESET_I),
    .start_i     (acq_start),
    .stop_i      (state != ST_ACQ),
    .resp_time_i (RESP_TIME_I),
    .active_o    (acq_active),
    .done_o      (acq_done)
  );

  // checks
  sequence s_user_fast;
    (state != ST_TUNE) && ctrl_wr && (new_sel == SEL_FAST);
  endsequence
  sequence s_fast_run;
    (state == ST_TUNE) && TUNE_FAST_O && TUNE_START_O && ONOFF_MODE_O;
  endsequence

  property p_off_no_start;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (state == ST_IDLE && sel == SEL_OFF && !user_req) |=> (state != ST_TUNE);
  endproperty
  a_off_no_start: assert property (p_off_no_start) else $error("tuning started while off");

  property p_fast_start;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    s_user_fast |=> s_fast_run ##1 !TUNE_START_O;
  endproperty
  a_fast_start: assert property (p_fast_start) else $error("quick run not started");

  property p_user_done;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (tune_done && kind == KIND_USER && !ctrl_wr)
      |=> (state == ST_IDLE) && (sel == SEL_OFF) && (GAINS_O == $past(TUNE_GAINS_I));
  endproperty
  a_user_done: assert property (p_user_done) else $error("operator run end wrong");

  property p_ind_run;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    ((state == ST_TUNE) |-> TUNING_IND_O) and
    ((state == ST_IDLE || state == ST_MON) |-> !TUNING_IND_O);
  endproperty
  a_ind_run: assert property (p_ind_run) else $error("indicator wrong");

  property p_onoff;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    ONOFF_MODE_O == (state == ST_TUNE);
  endproperty
  a_onoff: assert property (p_onoff) else $error("control action wrong");

  property p_self_enable;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (state == ST_IDLE && self_sel && run && !user_req)
      |=> (state == (($past(ref_valid) &&
                      !($past(ctl_rst) && $past(sel) == SEL_EACH)) ? ST_MON : ST_TUNE));
  endproperty
  a_self_enable: assert property (p_self_enable) else $error("self start wrong");

  property p_clear_ref;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (user_req && (new_sel == SEL_FAST || new_sel == SEL_FULL)) |=> !ref_valid;
  endproperty
  a_clear_ref: assert property (p_clear_ref) else $error("reference not cleared");

  property p_acq_after;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    acq_start |=> (state == ST_ACQ) && ACQ_ACTIVE_O && acq_active && TUNING_IND_O;
  endproperty
  a_acq_after: assert property (p_acq_after) else $error("no acquisition");

  property p_acq_end;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (state == ST_ACQ && acq_done && self_sel && run && !user_req && !ctl_rst)
      |=> (state == ST_MON) && !TUNING_IND_O && !ONOFF_MODE_O && MON_ACTIVE_O && ref_valid;
  endproperty
  a_acq_end: assert property (p_acq_end) else $error("acquisition end wrong");

  property p_retune;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (state == ST_MON && DEVIATION_I && self_sel && run && !user_req)
      |=> (state == ST_TUNE) && TUNE_START_O && !TUNE_FAST_O;
  endproperty
  a_retune: assert property (p_retune) else $error("no retune on deviation");

  property p_adapt_done;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    (tune_done && kind == KIND_ADAPT && !ctrl_wr) |=> (sel == SEL_SELF) && (state == ST_ACQ);
  endproperty
  a_adapt_done: assert property (p_adapt_done) else $error("adapt switch missing");

  property p_each_reset;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    ((state == ST_ACQ || state == ST_MON) && sel == SEL_EACH && run && ctl_rst && !user_req)
      |=> (state == ST_TUNE);
  endproperty
  a_each_reset: assert property (p_each_reset) else $error("no run on reset");

  property p_one_start;
    @(posedge CLK_SYS_I) disable iff (RESET_I)
    TUNE_START_O |=> !TUNE_START_O;
  endproperty
  a_one_start: assert property (p_one_start) else $error("start not single");

endmodule

// ---- sim/ats_tune_model.sv ----
// tuning engine stand-in: answers each start with one done pulse
// assumes start is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module ats_tune_model
  import ats_pkg::*;
#(
  parameter int DLY = 6
)(
  // clock
  input  wire logic clk_i,
  // run request
  input  wire logic start_i,
  input  wire logic fast_i,
  // answer and bookkeeping
  output logic       done_o,
  output ats_gains_t gains_o,
  output int         n_start,
  output logic       last_fast
);
  int cnt;

  // idle values
  initial
  begin
    cnt = 0;
    n_start = 0;
    last_fast = 1'b0;
    done_o = 1'b0;
    gains_o = '0;
  end

  // count starts, answer after a fixed delay, gains junk outside done
  always @(posedge clk_i)
  begin
    if (start_i)
    begin
      n_start <= n_start + 1;
      last_fast <= fast_i;
      cnt <= DLY;
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
    done_o <= (cnt == 1) && !start_i; // single pulse
    if (cnt == 1 && !start_i)
      gains_o <= '{d: 16'(n_start), i: 16'h0002, p: 16'h0001};
    else
      gains_o <= ~gains_o;
  end
endmodule

// ---- sim/test_ats_sequencer.sv ----
// bench for the autotune mode sequencer: bus tasks, one task per scenario
// assumes the tuning engine stand-in ats_tune_model
`timescale 1ns/1ps
module test_ats_sequencer
  import ats_pkg::*;
;
  logic        clk = 0, rst = 1, dev = 0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awr, wr_r, bv, arr, rv, start, fast, done, acq, mon, ind, onoff, ind_q, last_fast;
  logic [15:0] resp = 16'h0001;
  ats_gains_t  g_in, gains;
  int          n_start, fails = 0, n_tests = 0, acq_n = 0, tgl = 0;

  ats_sequencer #(.FLASH_CYC(4), .UNIT_CYC(3)) u_ats_sequencer (
    .CLK_SYS_I(clk), .RESET_I(rst),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready),
    .TUNE_START_O(start), .TUNE_FAST_O(fast), .TUNE_DONE_I(done),
    .TUNE_GAINS_I(g_in), .RESP_TIME_I(resp), .ACQ_ACTIVE_O(acq),
    .MON_ACTIVE_O(mon), .DEVIATION_I(dev), .TUNING_IND_O(ind),
    .ONOFF_MODE_O(onoff), .GAINS_O(gains)
  );

  ats_tune_model u_ats_tune_model (
    .clk_i(clk), .start_i(start), .fast_i(fast), .done_o(done),
    .gains_o(g_in), .n_start(n_start), .last_fast(last_fast)
  );

  // 200 MHz clock
  initial
  begin
    forever #2.5 clk = ~clk;
  end

  // time the acquisition stage and count indicator flips in it
  always @(posedge clk)
  begin
    ind_q <= ind;
    if (acq)
      acq_n <= acq_n + 1;
    if (acq && ind !== ind_q)
      tgl <= tgl + 1;
  end

  task chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task wr(input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= OFF_CTRL;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    while (n < 50)
    begin
      @(posedge clk);
      n++;
      if (awr) awv <= 0;
      if (wr_r) wv <= 0;
      if (bv === 1'b1) break;
    end
    chk({bv, bresp}, {1'b1, RESP_OKAY});
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1;
    rready <= 1;
    while (n < 50)
    begin
      @(posedge clk);
      n++;
      if (arr) arv <= 0;
      if (rv === 1'b1) break;
    end
    d = rdata;
    r = rresp;
  endtask

  // status fields: state, reference valid, monitoring, selection
  task cs(input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(OFF_STATUS, d, r);
    chk(d & 32'h0000_0733, e);
  endtask

  task wacq(input logic v);
    int n;
    for (n = 0; n < 400 && acq !== v; n++) @(posedge clk);
  endtask

  task s_off;
    wr(32'h0000_0008);
    repeat (20) @(posedge clk);
    chk(n_start, 0);
    cs(32'h0000_0000);
  endtask

  task s_self;
    int a1, b, t0;
    wr(32'h0000_000B);
    wacq(1);
    chk(n_start, 1);
    b = acq_n;
    t0 = tgl;
    wacq(0);
    a1 = acq_n - b;
    chk((tgl - t0) > 1, 1);
    @(posedge clk);
    chk({ind, onoff, mon}, 3'b001);
    cs(32'h0000_0333);
    // only the response time moves; no setpoint or power change mid-run
    resp <= 16'h0002;
    dev <= 1'b1;
    @(posedge clk);
    dev <= 1'b0;
    wacq(1);
    chk(n_start, 2);
    b = acq_n;
    wacq(0);
    chk(acq_n - b - a1, 12);
  endtask

  task s_skip;
    wr(32'h0000_0003);
    cs(32'h0000_0310);
    wr(32'h0000_000B);
    repeat (3) @(posedge clk);
    chk(n_start, 2);
    cs(32'h0000_0333);
  endtask

  task s_user(input logic [2:0] s, input logic f);
    int n0, n;
    n0 = n_start;
    wr(32'(s));
    @(posedge clk);
    chk(n_start, n0 + 1);
    chk({last_fast, ind, onoff}, {f, 2'b11});
    for (n = 0; n < 50 && onoff !== 1'b0; n++) @(posedge clk);
    @(posedge clk);
    chk({ind, onoff}, 0);
    chk(gains, {16'(n0 + 1), 16'h0002, 16'h0001});
    cs(32'h0000_0000);
  endtask

  task s_adapt;
    int n0;
    resp <= 16'h0001;
    wr(32'h0000_000C);
    wacq(1);
    cs(32'h0000_0302);
    wr(32'h0000_000D);
    n0 = n_start;
    wr(32'h0000_001D);
    @(posedge clk);
    chk(n_start, n0 + 1);
  endtask

  task s_bad;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h20, d, r);
    chk({d, r}, {32'h0000_0000, RESP_SLVERR});
  endtask

  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    s_off;
    s_self;
    s_skip;
    s_user(SEL_FAST, 1'b1);
    s_user(SEL_FULL, 1'b0);
    s_adapt;
    s_bad;
    close_out;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out;
  end
endmodule
